// ---- ctfp_top.sv ----
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module ctfp_top import ctfp_pkg::*; #(
  parameter logic [16:0] FILT_LONG_N = FILT_N_LONG
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [5:0] programmable_function_pin_i,
  output logic [3:0] programmable_function_pin_o,
  output logic [3:0] programmable_function_pin_oe,
  input wire logic [7:0] tbus_i,
  output logic [7:0] tbus_o,
  output logic [7:0] tbus_oe
);
  ctfp_ctrl_type ctrl_r [2];
  logic [31:0] load_r [2];
  logic [31:0] npul_r [2];
  logic [31:0] count_r [2];
  logic [31:0] capt_r [2];
  logic [31:0] pulses_r [2];
  ctfp_st_type st_r [2];
  logic [2:0] pre_r [2];
  logic [1:0] src_prev_r, gate_prev_r, arm_prev_r, pend_r, out_r;
  logic [15:0] rpin_r;
  logic [31:0] rtbus_r;
  logic [27:0] filt_r;
  logic [16:0] freq_r;
  logic [15:0] fcnt_r;
  logic frequency_generator_output_r;
  logic [6:0] acc_r;
  logic samp_en_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic [NUM_IN-1:0] raw_in, filt_lv;
  logic [1:0] tc, io, src_lv, gate_lv, arm_lv, src_int, tick, src_rise, gate_rise, arm_rise;
  logic [1:0] pause_ok, cnt_en, tcev, cap_ev, cmd_arm, cmd_disarm;
  logic [2:0] wrap [2];
  logic wr_ev, ci;
  logic [31:0] rdata;
  logic [7:0] sadr;

  function automatic logic pick(input logic [3:0] s, input logic [NUM_IN-1:0] v, input logic o, input logic t);
    if (s == SEL_OTHER_OUT) pick = o;
    else if (s == SEL_OTHER_TC) pick = t;
    else pick = v[s];
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      wmerge[8*b+:8] = s[b] ? d[8*b+:8] : o[8*b+:8];
    end
  endfunction

  // 40 mhz sample enable, four of five clocks
  always_ff @(posedge clock) begin
    if (srst) begin
      acc_r <= 7'h00;
      samp_en_r <= 1'b0;
    end else if (acc_r + FILT_CLK_MHZ >= SYS_CLK_MHZ) begin
      acc_r <= acc_r + FILT_CLK_MHZ - SYS_CLK_MHZ;
      samp_en_r <= 1'b1;
    end else begin
      acc_r <= acc_r + FILT_CLK_MHZ;
      samp_en_r <= 1'b0;
    end
  end

  assign raw_in = {tbus_i, programmable_function_pin_i};

  for (genvar i = 0; i < NUM_IN; i++) begin : g_filt
    ctfp_filter #(.LONG_N(FILT_LONG_N)) u_filt (
      .clock(clock),
      .srst(srst),
      .sample_en(samp_en_r),
      .setting(filt_r[2*i+:2]),
      .din(raw_in[i]),
      .dout(filt_lv[i])
    );
  end

  // bus decode
  assign wr_ev = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
  assign ci = wb_adr_i[5];
  assign sadr = wb_adr_i & (CTR_STRIDE - 8'h01);
  always_comb begin
    for (int n = 0; n < 2; n++) begin
      cmd_arm[n] = wr_ev && wb_adr_i == ADR_CMD && wb_sel_i[0] && wb_dat_i[n];
      cmd_disarm[n] = wr_ev && wb_adr_i == ADR_CMD && wb_sel_i[0] && wb_dat_i[n+2];
    end
  end

  // per-counter signal selection
  always_comb begin
    for (int n = 0; n < 2; n++) begin
      tc[n] = count_r[n] == 32'h0;
      io[n] = out_r[n] ^ ctrl_r[n].out_pol;
    end
    for (int n = 0; n < 2; n++) begin
      gate_lv[n] = pick(ctrl_r[n].gate_sel, filt_lv, io[1-n], tc[1-n]);
      src_lv[n] = pick(ctrl_r[n].src_sel, filt_lv, 1'b0, tc[1-n]);
      arm_lv[n] = pick(ctrl_r[n].arm_sel, filt_lv, io[1-n], tc[1-n]);
      src_int[n] = ctrl_r[n].src_sel == SEL_CLK;
      src_rise[n] = src_lv[n] && !src_prev_r[n];
      gate_rise[n] = gate_lv[n] && !gate_prev_r[n];
      arm_rise[n] = arm_lv[n] && !arm_prev_r[n];
      wrap[n] = ctrl_r[n].prescale == PRE_8X ? PRE_8X_WRAP : ctrl_r[n].prescale == PRE_2X ? PRE_2X_WRAP : 3'h0;
      tick[n] = src_int[n] || (src_rise[n] && pre_r[n] == wrap[n]);
      pause_ok[n] = !(ctrl_r[n].pause_en && ctrl_r[n].mode != MODE_FINITE)
        || (gate_lv[n] ^ ctrl_r[n].pause_inv);
      cnt_en[n] = st_r[n] == ST_RUN && tick[n] && pause_ok[n];
      tcev[n] = cnt_en[n] && tc[n] && ctrl_r[n].mode != MODE_EDGE;
      cap_ev[n] = st_r[n] == ST_RUN && ctrl_r[n].mode == MODE_EDGE && !ctrl_r[n].pause_en
        && (ctrl_r[n].dup_prev ? gate_rise[n] : pend_r[n] && tick[n]);
    end
  end

  // counter cores
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int n = 0; n < 2; n++) begin
        st_r[n] <= ST_IDLE;
        count_r[n] <= 32'h0;
        capt_r[n] <= 32'h0;
        pulses_r[n] <= 32'h0;
        pre_r[n] <= 3'h0;
      end
      src_prev_r <= 2'h0;
      gate_prev_r <= 2'h0;
      arm_prev_r <= 2'h0;
      pend_r <= 2'h0;
    end else begin
      src_prev_r <= src_lv;
      gate_prev_r <= gate_lv;
      arm_prev_r <= arm_lv;
      for (int n = 0; n < 2; n++) begin
        if (src_rise[n] && !src_int[n]) begin
          pre_r[n] <= pre_r[n] == wrap[n] ? 3'h0 : pre_r[n] + 3'h1;
        end
        if (cmd_disarm[n]) begin
          st_r[n] <= ST_IDLE;
        end else if (cmd_arm[n] || (st_r[n] == ST_IDLE && ctrl_r[n].hardware_arm_input_en && arm_rise[n])) begin
          st_r[n] <= (ctrl_r[n].mode != MODE_EDGE && ctrl_r[n].start_en) ? ST_WAIT : ST_RUN;
          count_r[n] <= load_r[n];
          pulses_r[n] <= 32'h0;
          pre_r[n] <= 3'h0;
          pend_r[n] <= 1'b0;
        end else begin
          unique case (st_r[n])
            ST_IDLE: begin
            end
            ST_WAIT: begin
              if (gate_rise[n]) begin
                st_r[n] <= ST_RUN;
                count_r[n] <= load_r[n];
                pulses_r[n] <= 32'h0;
              end
            end
            ST_RUN: begin
              if (ctrl_r[n].mode == MODE_EDGE) begin
                if (!ctrl_r[n].dup_prev && gate_rise[n]) begin
                  pend_r[n] <= 1'b1;
                end else if (cap_ev[n]) begin
                  pend_r[n] <= 1'b0;
                end
                if (cap_ev[n]) begin
                  capt_r[n] <= count_r[n];
                  count_r[n] <= 32'h0;
                end else if (cnt_en[n]) begin
                  count_r[n] <= ctrl_r[n].count_down ? count_r[n] - 32'h1 : count_r[n] + 32'h1;
                end
              end else if (ctrl_r[n].mode == MODE_FINITE && ctrl_r[n].retrig && ctrl_r[n].start_en
                  && gate_rise[n]) begin
                count_r[n] <= load_r[n];
                pulses_r[n] <= 32'h0;
              end else if (cnt_en[n]) begin
                if (tc[n]) begin
                  count_r[n] <= load_r[n];
                  pulses_r[n] <= pulses_r[n] + 32'h1;
                  if (ctrl_r[n].mode == MODE_FINITE && pulses_r[n] + 32'h1 == npul_r[n]) begin
                    st_r[n] <= (ctrl_r[n].retrig && ctrl_r[n].start_en) ? ST_WAIT : ST_IDLE;
                  end
                end else begin
                  count_r[n] <= count_r[n] - 32'h1;
                end
              end
            end
          endcase
        end
      end
    end
  end

  // internal output: pulse or toggle on tc
  always_ff @(posedge clock) begin
    if (srst) begin
      out_r <= 2'h0;
    end else begin
      for (int n = 0; n < 2; n++) begin
        if (st_r[n] != ST_RUN) out_r[n] <= 1'b0;
        else if (ctrl_r[n].out_toggle) out_r[n] <= out_r[n] ^ tcev[n];
        else out_r[n] <= tcev[n];
      end
    end
  end

  // frequency output generator
  always_ff @(posedge clock) begin
    if (srst || !freq_r[16]) begin
      fcnt_r <= 16'h0;
      frequency_generator_output_r <= 1'b0;
    end else if (fcnt_r == freq_r[15:0]) begin
      fcnt_r <= 16'h0;
      frequency_generator_output_r <= !frequency_generator_output_r;
    end else begin
      fcnt_r <= fcnt_r + 16'h1;
    end
  end

  // output routing, all undriven after reset
  always_ff @(posedge clock) begin
    if (srst) begin
      programmable_function_pin_o <= 4'h0;
      programmable_function_pin_oe <= 4'h0;
      tbus_o <= 8'h0;
      tbus_oe <= 8'h0;
    end else begin
      for (int p = 0; p < NUM_PIN_OUT; p++) begin
        programmable_function_pin_oe[p] <= rpin_r[4*p+:4] != RT_OFF && rpin_r[4*p+:4] <= RT_RAW_TBUS_MAX;
        unique case (rpin_r[4*p+:4])
          RT_CTR0: programmable_function_pin_o[p] <= io[0];
          RT_CTR1: programmable_function_pin_o[p] <= io[1];
          RT_FREQ: programmable_function_pin_o[p] <= frequency_generator_output_r;
          default: programmable_function_pin_o[p] <= tbus_i[3'(rpin_r[4*p+:4] - RT_RAW)];
        endcase
      end
      for (int t = 0; t < NUM_TBUS; t++) begin
        tbus_oe[t] <= rtbus_r[4*t+:4] != RT_OFF && rtbus_r[4*t+:4] != RT_FREQ
          && rtbus_r[4*t+:4] <= RT_RAW_PIN_MAX;
        unique case (rtbus_r[4*t+:4])
          RT_CTR0: tbus_o[t] <= io[0];
          RT_CTR1: tbus_o[t] <= io[1];
          default: tbus_o[t] <= programmable_function_pin_i[3'(rtbus_r[4*t+:4] - RT_RAW)];
        endcase
      end
    end
  end

  // register reads
  always_comb begin
    rdata = 32'h0;
    if (wb_adr_i < ADR_RPIN) begin
      unique case (sadr)
        ADR_CTRL: rdata = ctrl_r[ci];
        ADR_LOAD: rdata = load_r[ci];
        ADR_NPUL: rdata = npul_r[ci];
        ADR_COUNT: rdata = count_r[ci];
        ADR_CAPT: rdata = capt_r[ci];
        default: rdata = 32'h0;
      endcase
    end else begin
      unique case (wb_adr_i)
        ADR_RPIN: rdata = {16'h0, rpin_r};
        ADR_RTBUS: rdata = rtbus_r;
        ADR_FILT: rdata = {4'h0, filt_r};
        ADR_FREQ: rdata = {15'h0, freq_r};
        ADR_STAT: rdata = {24'h0, tc, io, st_r[1] == ST_RUN, st_r[0] == ST_RUN,
          st_r[1] != ST_IDLE, st_r[0] != ST_IDLE};
        default: rdata = 32'h0;
      endcase
    end
  end

  // wishbone slave: ack one clock after request, writes on the ack edge
  always_ff @(posedge clock) begin
    if (srst) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
      rdat_r <= rdata;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      for (int n = 0; n < 2; n++) begin
        ctrl_r[n] <= ctfp_ctrl_type'(CTRL_RST);
        load_r[n] <= 32'h0;
        npul_r[n] <= 32'h0;
      end
      rpin_r <= RPIN_RST;
      rtbus_r <= RTBUS_RST;
      filt_r <= FILT_RST;
      freq_r <= FREQ_RST;
    end else if (wr_ev) begin
      if (wb_adr_i < ADR_RPIN) begin
        if (sadr == ADR_CTRL) ctrl_r[ci] <= ctfp_ctrl_type'(wmerge(ctrl_r[ci], wb_dat_i, wb_sel_i));
        if (sadr == ADR_LOAD) load_r[ci] <= wmerge(load_r[ci], wb_dat_i, wb_sel_i);
        if (sadr == ADR_NPUL) npul_r[ci] <= wmerge(npul_r[ci], wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == ADR_RPIN) rpin_r <= 16'(wmerge({16'h0, rpin_r}, wb_dat_i, wb_sel_i));
      if (wb_adr_i == ADR_RTBUS) rtbus_r <= wmerge(rtbus_r, wb_dat_i, wb_sel_i);
      if (wb_adr_i == ADR_FILT) filt_r <= 28'(wmerge({4'h0, filt_r}, wb_dat_i, wb_sel_i));
      if (wb_adr_i == ADR_FREQ) freq_r <= 17'(wmerge({15'h0, freq_r}, wb_dat_i, wb_sel_i));
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  property p_hiz_start;
    $fell(srst) |-> programmable_function_pin_oe == 4'h0 && tbus_oe == 8'h0;
  endproperty
  a_hiz_start: assert property (p_hiz_start) else $error("outputs driven after reset");

  property p_no_freq_bus;
    rtbus_r[3:0] == RT_FREQ |=> !tbus_oe[0];
  endproperty
  a_no_freq_bus: assert property (p_no_freq_bus) else $error("frequency output on bus line");

  property p_idle_quiet;
    st_r[0] == ST_IDLE && !cmd_arm[0] && !arm_rise[0] |=> $stable(count_r[0]) && !out_r[0];
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle counter active");

  property p_start;
    st_r[0] == ST_WAIT && gate_rise[0] && !cmd_arm[0] && !cmd_disarm[0] |=> st_r[0] == ST_RUN;
  endproperty
  a_start: assert property (p_start) else $error("start trigger missed");

  property p_pause;
    st_r[0] == ST_RUN && ctrl_r[0].pause_en && ctrl_r[0].mode == MODE_EDGE
      && !(gate_lv[0] ^ ctrl_r[0].pause_inv) && !cmd_arm[0] |=> $stable(count_r[0]);
  endproperty
  a_pause: assert property (p_pause) else $error("counted while paused");

  property p_finite_stop;
    st_r[0] == ST_RUN && ctrl_r[0].mode == MODE_FINITE && tcev[0] && !ctrl_r[0].retrig
      && pulses_r[0] + 32'h1 == npul_r[0] && !cmd_arm[0] && !cmd_disarm[0] |=> st_r[0] == ST_IDLE;
  endproperty
  a_finite_stop: assert property (p_finite_stop) else $error("finite generation overran");

  property p_cascade;
    ctrl_r[1].gate_sel == SEL_OTHER_TC && count_r[0] == 32'h0 |-> gate_lv[1];
  endproperty
  a_cascade: assert property (p_cascade) else $error("cascade gate wrong");

  property p_presc;
    st_r[0] == ST_RUN && !src_int[0] && ctrl_r[0].prescale == PRE_8X && pre_r[0] != PRE_8X_WRAP |-> !cnt_en[0];
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler passed early");

  property p_dup_capt;
    cap_ev[0] && ctrl_r[0].dup_prev && !cmd_arm[0] && !cmd_disarm[0]
      |=> capt_r[0] == $past(count_r[0]) && count_r[0] == 32'h0;
  endproperty
  a_dup_capt: assert property (p_dup_capt) else $error("gate capture wrong");

  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

  c_finite_done: cover property (st_r[0] == ST_RUN && ctrl_r[0].mode == MODE_FINITE ##1 st_r[0] == ST_IDLE);
  c_capture: cover property (cap_ev[0] && ctrl_r[0].dup_prev);
  c_retrig: cover property (st_r[1] == ST_WAIT ##1 st_r[1] == ST_RUN);
  c_pin_drive: cover property (programmable_function_pin_oe[0] && programmable_function_pin_o[0]);
endmodule // ctfp_top
`default_nettype wire

// ---- ctfp_pkg.sv ----
`default_nettype none
package ctfp_pkg;
  // register byte offsets, counter n at n * CTR_STRIDE
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_LOAD = 8'h04;
  localparam logic [7:0] ADR_NPUL = 8'h08;
  localparam logic [7:0] ADR_COUNT = 8'h0c;
  localparam logic [7:0] ADR_CAPT = 8'h10;
  localparam logic [7:0] CTR_STRIDE = 8'h20;
  localparam logic [7:0] ADR_RPIN = 8'h40;
  localparam logic [7:0] ADR_RTBUS = 8'h44;
  localparam logic [7:0] ADR_FILT = 8'h48;
  localparam logic [7:0] ADR_FREQ = 8'h4c;
  localparam logic [7:0] ADR_STAT = 8'h50;
  localparam logic [7:0] ADR_CMD = 8'h54;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] RPIN_RST = 16'h0000;
  localparam logic [31:0] RTBUS_RST = 32'h0000_0000;
  localparam logic [27:0] FILT_RST = 28'h000_0000;
  localparam logic [16:0] FREQ_RST = 17'h0_0000;
  localparam int NUM_PIN_IN = 6;
  localparam int NUM_PIN_OUT = 4;
  localparam int NUM_TBUS = 8;
  localparam int NUM_IN = NUM_PIN_IN + NUM_TBUS;
  // filter settings and sample counts
  localparam logic [1:0] FILT_OFF = 2'h0;
  localparam logic [1:0] FILT_125NS = 2'h1;
  localparam logic [1:0] FILT_6US = 2'h2;
  localparam logic [16:0] FILT_N_SHORT = 17'h0_0005;
  localparam logic [16:0] FILT_N_MID = 17'h0_0101;
  localparam logic [16:0] FILT_N_LONG = 17'h1_8da8;
  // filter sample rate drawn from the system clock
  localparam logic [6:0] SYS_CLK_MHZ = 7'h32;
  localparam logic [6:0] FILT_CLK_MHZ = 7'h28;
  // prescaler
  localparam logic [1:0] PRE_NONE = 2'h0;
  localparam logic [1:0] PRE_2X = 2'h1;
  localparam logic [1:0] PRE_8X = 2'h2;
  localparam logic [2:0] PRE_2X_WRAP = 3'h1;
  localparam logic [2:0] PRE_8X_WRAP = 3'h7;
  // input selectors: 0..13 conditioned inputs
  localparam logic [3:0] SEL_OTHER_OUT = 4'he;
  localparam logic [3:0] SEL_OTHER_TC = 4'hf;
  localparam logic [3:0] SEL_CLK = 4'he;
  // output routing codes
  localparam logic [3:0] RT_OFF = 4'h0;
  localparam logic [3:0] RT_CTR0 = 4'h1;
  localparam logic [3:0] RT_CTR1 = 4'h2;
  localparam logic [3:0] RT_FREQ = 4'h3;
  localparam logic [3:0] RT_RAW = 4'h4;
  localparam logic [3:0] RT_RAW_PIN_MAX = 4'h9;
  localparam logic [3:0] RT_RAW_TBUS_MAX = 4'hb;
  typedef enum logic [1:0] {MODE_EDGE, MODE_CONT, MODE_FINITE, MODE_RSVD} ctfp_mode_type;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} ctfp_st_type;
  typedef struct packed {
    logic [3:0] rsvd_hi;
    logic out_pol;
    logic out_toggle;
    logic count_down;
    logic dup_prev;
    logic [1:0] prescale;
    logic [3:0] src_sel;
    logic [3:0] gate_sel;
    logic retrig;
    logic pause_inv;
    logic pause_en;
    logic start_en;
    ctfp_mode_type mode;
    logic [3:0] arm_sel;
    logic hardware_arm_input_en;
    logic [2:0] rsvd_lo;
  } ctfp_ctrl_type;
endpackage
`default_nettype wire

// ---- ctfp_filter.sv ----
`timescale 1ns/1ns
`default_nettype none
module ctfp_filter import ctfp_pkg::*; #(
  parameter logic [16:0] LONG_N = FILT_N_LONG
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic sample_en,
  input wire logic [1:0] setting,
  input wire logic din,
  output logic dout
);
  logic [16:0] cnt_r;
  logic lvl_r;
  logic [16:0] n_sel;

  always_comb begin
    unique case (setting)
      FILT_125NS: n_sel = FILT_N_SHORT;
      FILT_6US: n_sel = FILT_N_MID;
      default: n_sel = LONG_N;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      lvl_r <= 1'b0;
      cnt_r <= 17'h0_0000;
    end else if (setting == FILT_OFF) begin
      lvl_r <= din;
      cnt_r <= 17'h0_0000;
    end else if (sample_en) begin
      if (din == lvl_r) begin
        cnt_r <= 17'h0_0000;
      end else if (cnt_r == n_sel - 17'h0_0001) begin
        lvl_r <= din;
        cnt_r <= 17'h0_0000;
      end else begin
        cnt_r <= cnt_r + 17'h0_0001;
      end
    end
  end

  assign dout = lvl_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  property p_filt_pass;
    (setting != FILT_OFF) && $past(setting) != FILT_OFF && $changed(lvl_r)
      |-> $past(sample_en) && $past(cnt_r) == $past(n_sel) - 17'h0_0001;
  endproperty
  a_filt_pass: assert property (p_filt_pass) else $error("filter output changed before n samples");

  property p_filt_restart;
    sample_en && setting != FILT_OFF && din == lvl_r |=> cnt_r == 17'h0_0000;
  endproperty
  a_filt_restart: assert property (p_filt_restart) else $error("filter run not restarted");

  c_filt_change: cover property (setting == FILT_125NS && $changed(lvl_r));
endmodule // ctfp_filter
`default_nettype wire

// ---- ctfp_src_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module ctfp_src_model (
  input wire logic clock,
  output logic [5:0] pin_lvl,
  output logic [7:0] bus_lvl
);
  initial begin
    pin_lvl = 6'h00;
    bus_lvl = 8'h00;
  end
  // one pulse on an input pin, high then low for given clocks
  task automatic pulse(input int idx, input int hi, input int lo);
    @(posedge clock);
    pin_lvl[idx] <= 1'b1;
    repeat (hi) @(posedge clock);
    pin_lvl[idx] <= 1'b0;
    repeat (lo) @(posedge clock);
  endtask
  task automatic set_pin(input int idx, input logic v);
    @(posedge clock);
    pin_lvl[idx] <= v;
  endtask
  task automatic set_bus(input int idx, input logic v);
    @(posedge clock);
    bus_lvl[idx] <= v;
  endtask
endmodule // ctfp_src_model
`default_nettype wire

// ---- ctfp_top_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module ctfp_top_tb import ctfp_pkg::*;;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [3:0] po;
  logic [3:0] poe;
  logic [7:0] to;
  logic [7:0] toe;
  logic [5:0] pin_lvl;
  logic [7:0] bus_lvl;
  logic [7:0] tbus_w;
  logic [31:0] rd;
  int err_count = 0;
  int compares = 0;
  int n;
  int k;
  int nf;
  assign tbus_w = (toe & to) | (~toe & bus_lvl);
  initial begin
    forever #10 clock = ~clock;
  end
  ctfp_src_model src (.clock(clock), .pin_lvl(pin_lvl), .bus_lvl(bus_lvl));
  ctfp_top #(.FILT_LONG_N(17'h0_0010)) ctfp_top_inst (
    .clock(clock), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .programmable_function_pin_i(pin_lvl), .programmable_function_pin_o(po),
    .programmable_function_pin_oe(poe), .tbus_i(tbus_w), .tbus_o(to), .tbus_oe(toe)
  );
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clock);
      t++;
    end while (ack !== 1'b1 && t < 50);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (t >= 50) err_count++;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  // clocks until the next change of output pin 0
  task automatic gap(output int c);
    logic v;
    v = po[0];
    c = 0;
    do begin
      @(posedge clock);
      c++;
    end while (po[0] === v && c < 100);
  endtask
  // rising edges seen on output pin 0 within len clocks
  task automatic rises(input int len, output int r);
    logic v;
    v = po[0];
    r = 0;
    repeat (len) begin
      @(posedge clock);
      if (po[0] === 1'b1 && v !== 1'b1) r++;
      v = po[0];
    end
  endtask
  task automatic rearm(input logic [31:0] ctrl);
    wb(1'b1, ADR_CMD, 32'h4);
    wb(1'b1, ADR_CTRL, ctrl);
    wb(1'b1, ADR_CMD, 32'h1);
  endtask
  initial begin
    #(20 * 40000);
    err_count++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h723d));
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    `CHK(poe, 4'h0)
    `CHK(toe, 8'h00)
    rdc(ADR_FILT, {4'h0, FILT_RST});
    rdc(ADR_CTRL, CTRL_RST);
    rdc(8'hfc, 32'h0);
    $display("test reset done");
    wb(1'b1, ADR_LOAD, 32'h0);
    wb(1'b1, ADR_CTRL, 32'h0004_0000);
    repeat (3) src.pulse(1, 3, 3);
    rdc(ADR_COUNT, 32'h0);
    wb(1'b1, ADR_CMD, 32'h1);
    n = $urandom_range(10, 1);
    repeat (n) src.pulse(1, 3, 3);
    rdc(ADR_COUNT, 32'(n));
    $display("test edge count done");
    src.set_pin(2, 1'b0);
    rearm(32'h0004_8800);
    repeat (4) src.pulse(1, 3, 3);
    rdc(ADR_COUNT, 32'h0);
    src.set_pin(2, 1'b1);
    repeat (3) src.pulse(1, 3, 3);
    rdc(ADR_COUNT, 32'h3);
    $display("test pause done");
    for (int m = 0; m < 2; m++) begin
      rearm(m == 0 ? 32'h0044_0000 : 32'h0084_0000);
      n = $urandom_range(4, 1);
      repeat ((m == 0 ? 2 : 8) * n) src.pulse(1, 3, 3);
      rdc(ADR_COUNT, 32'(n));
    end
    $display("test prescale done");
    for (int s = 1; s < 4; s++) begin
      nf = (s == 1) ? 5 : (s == 2) ? 257 : 16;
      wb(1'b1, ADR_FILT, 32'(s) << 2);
      rearm(32'h0004_0000);
      src.pulse(1, nf - 2, nf * 2 + 8);
      rdc(ADR_COUNT, 32'h0);
      src.pulse(1, nf * 2 + 8, nf * 2 + 8);
      rdc(ADR_COUNT, 32'h1);
    end
    $display("test filter done");
    n = $urandom_range(5, 1);
    wb(1'b1, ADR_FREQ, 32'h0001_0000 | 32'(n));
    wb(1'b1, ADR_RPIN, 32'h43);
    wb(1'b1, ADR_RTBUS, 32'h13);
    repeat (3) @(posedge clock);
    `CHK(poe[1:0], 2'b11)
    `CHK(toe[1:0], 2'b10)
    gap(k);
    gap(k);
    `CHK(k, n + 1)
    $display("test frequency output done");
    wb(1'b1, ADR_FILT, 32'h2000);
    for (int i = 0; i < 4; i++) begin
      src.set_bus(0, i[0] ^ 1'b1);
      repeat (4) @(posedge clock);
      `CHK(po[1], i[0] ^ 1'b1)
    end
    $display("test raw route done");
    wb(1'b1, ADR_FILT, 32'h0);
    wb(1'b1, ADR_RPIN, 32'h41);
    k = $urandom_range(6, 1);
    n = $urandom_range(5, 1);
    wb(1'b1, ADR_LOAD, 32'(k));
    wb(1'b1, ADR_NPUL, 32'(n));
    rearm(32'h0038_0200);
    rises((n + 2) * (k + 1) + 8, nf);
    `CHK(nf, n)
    wb(1'b0, ADR_STAT, 32'h0);
    `CHK(rd[0], 1'b0)
    $display("test finite done");
    rearm(32'h0038_0900);
    rises(4 * (k + 1), nf);
    `CHK(nf, 0)
    src.set_pin(0, 1'b1);
    repeat (2 * k + 10) @(posedge clock);
    rises(4 * (k + 1), nf);
    `CHK(nf, 4)
    wb(1'b1, ADR_CMD, 32'h4);
    repeat (4) @(posedge clock);
    rises(4 * (k + 1), nf);
    `CHK(nf, 0)
    $display("test continuous done");
    src.set_pin(0, 1'b0);
    rearm(32'h0038_2600);
    rises(4 * (k + 1), nf);
    `CHK(nf, 0)
    for (int r = 0; r < 2; r++) begin
      src.pulse(0, 2, 2);
      rises((n + 2) * (k + 1) + 8, nf);
      `CHK(nf, n)
    end
    $display("test start trigger done");
    wb(1'b1, ADR_LOAD, 32'(n));
    rearm(32'h0204_0000);
    wb(1'b1, ADR_CTRL + CTR_STRIDE, 32'h003b_c800);
    wb(1'b1, ADR_CMD, 32'h2);
    repeat (20) @(posedge clock);
    rdc(ADR_COUNT + CTR_STRIDE, 32'h0);
    repeat (n) src.pulse(1, 3, 3);
    rdc(ADR_COUNT, 32'h0);
    wb(1'b0, ADR_STAT, 32'h0);
    `CHK(rd[6], 1'b1)
    wb(1'b0, ADR_COUNT + CTR_STRIDE, 32'h0);
    `CHK(rd != 32'h0, 1'b1)
    $display("test cascade done");
    nf = $urandom_range(6, 1);
    wb(1'b1, ADR_LOAD, 32'h0);
    rearm(32'h0104_0000);
    repeat (nf) src.pulse(1, 3, 3);
    src.set_pin(0, 1'b1);
    repeat (4) @(posedge clock);
    rdc(ADR_CAPT, 32'(nf));
    src.set_pin(0, 1'b0);
    src.set_pin(0, 1'b1);
    repeat (4) @(posedge clock);
    rdc(ADR_CAPT, 32'h0);
    $display("test capture done");
    report_and_stop();
  end
endmodule // ctfp_top_tb
`default_nettype wire
